// *** src/gsc_cfg.svh ***
`ifndef GSC_CFG_SVH
`define GSC_CFG_SVH
// ascii characters
`define GSC_CH_SP 8'h20
`define GSC_CH_CR 8'h0d
`define GSC_CH_LF 8'h0a
`define GSC_CH_0 8'h30
`define GSC_CH_9 8'h39
// command letters
`define GSC_CMD_FILT 8'h5a
`define GSC_CMD_RAW 8'h7a
`define GSC_CMD_SCALE 8'h2e
`define GSC_CMD_MODE 8'h4b
`define GSC_CMD_FSET 8'h41
`define GSC_CMD_FGET 8'h61
// values and limits
`define GSC_SCALE_LO 16'h000a
`define GSC_SCALE_HI 16'h0064
`define GSC_FILT_RST 8'h10
`define GSC_MODE_MAX 10'h002
`define GSC_FILT_MAX 10'h0ff
`define GSC_MAX_DIGITS 2'h3
`define GSC_DEC_BASE 16'h000a
`define GSC_DEC_BASE10 10'h00a
`define GSC_LINE_BYTES 4'ha
`define GSC_NV_POLL 2'h2
// timing: two reports per second
`define GSC_REPORT_MS 500
`define GSC_CLK_MHZ 100
`define GSC_REPORT_CYC (`GSC_REPORT_MS * 1000 * `GSC_CLK_MHZ)
// register map, byte addresses
`define GSC_REG_STATUS 12'h000
`define GSC_REG_FILTER 12'h004
`define GSC_REG_MEAS 12'h008
`define GSC_REG_DISCARD 12'h00c
`define GSC_RESP_OKAY 2'b00
`define GSC_RESP_SLVERR 2'b10
`endif

// *** src/gsc_cmd_port.sv ***
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`include "gsc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module gsc_cmd_port #(
    parameter int REPORT_CYCLES = `GSC_REPORT_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // received command bytes
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    output logic rxReady,
    // transmitted reply bytes
    output logic txValid,
    output logic [7:0] txData,
    input wire logic txReady,
    // measurement core and strap
    input wire gsc_pkg::gsc_meas_t meas,
    input wire logic rangeHigh,
    // nonvolatile mode store
    input wire logic [1:0] nvMode,
    output logic nvStore,
    output logic [1:0] nvModeOut,
    // settings to the measurement core
    output gsc_pkg::gsc_mode_t mode,
    output logic [7:0] filterVal,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import gsc_pkg::*;

    function automatic logic [39:0] gsc_dec5(input logic [15:0] v);
        logic [15:0] r;
        logic [39:0] s;
        r = v;
        s = '0;
        for (int i = 0; i < 5; i++) begin
            s[i*8 +: 8] = `GSC_CH_0 + 8'(r % `GSC_DEC_BASE);
            r = r / `GSC_DEC_BASE;
        end
        return s;
    endfunction : gsc_dec5

    gsc_pst_t pst_ff, nxt_pst;
    gsc_mode_t mode_ff;
    logic bootDone_ff;
    logic [7:0] letter_ff, filter_ff;
    logic [9:0] param_ff, nxt_param;
    logic [1:0] ndig_ff, nxt_ndig;
    logic hasP_ff, nxt_hasP, bad_ff, nxt_bad, pend_ff;
    logic [79:0] line_ff;
    logic [3:0] txLeft_ff;
    logic due_ff;
    logic [25:0] tick_ff;
    logic nvStore_ff;
    logic [1:0] nvModeOut_ff;
    logic [15:0] discard_ff;
    logic bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;

    // byte parser
    wire rxTake = rxValid && rxReady;
    wire isDigit = (rxData >= `GSC_CH_0) && (rxData <= `GSC_CH_9);
    wire isLf = rxData == `GSC_CH_LF;
    wire isCr = rxData == `GSC_CH_CR;
    wire lineEnd = rxTake && isLf;
    wire lineGood = lineEnd && (pst_ff == GSC_P_LF) && !bad_ff;
    wire lineBad = lineEnd && (pst_ff != GSC_P_LETTER) && !lineGood;
    wire [9:0] digitVal = {2'b00, rxData - `GSC_CH_0};
    assign rxReady = !pend_ff;

    always_comb begin
        nxt_pst = pst_ff;
        nxt_param = param_ff;
        nxt_ndig = ndig_ff;
        nxt_hasP = hasP_ff;
        nxt_bad = bad_ff;
        if (rxTake) begin
            unique case (pst_ff)
                GSC_P_LETTER: begin
                    nxt_hasP = 1'b0;
                    nxt_bad = isCr;
                    nxt_pst = isLf ? GSC_P_LETTER : GSC_P_AFTER;
                end
                GSC_P_AFTER: begin
                    if (isCr) begin
                        nxt_pst = GSC_P_LF;
                    end else if (rxData == `GSC_CH_SP) begin
                        nxt_pst = GSC_P_DIGITS;
                        nxt_param = '0;
                        nxt_ndig = '0;
                        nxt_hasP = 1'b1;
                    end else begin
                        nxt_bad = 1'b1;
                    end
                end
                GSC_P_DIGITS: begin
                    if (isCr) begin
                        nxt_pst = GSC_P_LF;
                        nxt_bad = bad_ff || (ndig_ff == '0);
                    end else if (isDigit && ndig_ff != `GSC_MAX_DIGITS) begin
                        nxt_param = 10'(param_ff * `GSC_DEC_BASE10 + digitVal);
                        nxt_ndig = ndig_ff + 2'b01;
                    end else begin
                        nxt_bad = 1'b1;
                    end
                end
                GSC_P_LF: begin
                    nxt_bad = bad_ff || !isLf;
                end
            endcase
            if (isLf) begin
                nxt_pst = GSC_P_LETTER;
            end
        end
    end

    // command decode
    wire isFilt = letter_ff == `GSC_CMD_FILT;
    wire isRaw = letter_ff == `GSC_CMD_RAW;
    wire isScale = letter_ff == `GSC_CMD_SCALE;
    wire isMode = letter_ff == `GSC_CMD_MODE;
    wire isFset = letter_ff == `GSC_CMD_FSET;
    wire isFget = letter_ff == `GSC_CMD_FGET;
    wire sleeping = mode_ff == GSC_SLEEP;
    wire okMeas = (isFilt || isRaw) && !hasP_ff && !sleeping;
    wire okPlain = (isScale || isFget) && !hasP_ff;
    wire okMode = isMode && hasP_ff && (param_ff <= `GSC_MODE_MAX);
    wire okFset = isFset && hasP_ff && (param_ff <= `GSC_FILT_MAX);
    wire cmdOk = okMeas || okPlain || okMode || okFset;
    wire [15:0] scaleVal = rangeHigh ? `GSC_SCALE_HI : `GSC_SCALE_LO;
    wire [15:0] cmdVal = isFilt ? meas.filt :
        isRaw ? meas.raw :
        isScale ? scaleVal :
        isFget ? {8'h00, filter_ff} :
        {6'h00, param_ff};

    // transmit scheduling
    wire txBusy = txLeft_ff != '0;
    wire tick = (mode_ff == GSC_STREAM) && (tick_ff == 26'(REPORT_CYCLES - 1));
    wire dueGo = due_ff && !txBusy && (mode_ff == GSC_STREAM);
    wire cmdGo = pend_ff && !txBusy && !dueGo &&
        !((mode_ff == GSC_STREAM) && meas.busy);
    wire cmdSend = cmdGo && cmdOk;
    wire txStart = dueGo || cmdSend;
    wire [7:0] outLetter = dueGo ? `GSC_CMD_FILT : letter_ff;
    wire [15:0] outVal = dueGo ? meas.filt : cmdVal;
    wire [79:0] newLine = {`GSC_CH_SP, outLetter, `GSC_CH_SP, gsc_dec5(outVal),
        `GSC_CH_CR, `GSC_CH_LF};
    wire txShift = txValid && txReady;
    assign txValid = txBusy;
    assign txData = line_ff[79:72];
    wire setMode = cmdSend && okMode;
    wire [1:0] nvRestore = (nvMode == `GSC_NV_POLL) ? 2'(GSC_POLL) : 2'(GSC_STREAM);

    // axi4-lite slave
    wire wrTake = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
    wire wrFilter = wrTake && (s_axi_awaddr == `GSC_REG_FILTER) && s_axi_wstrb[0];
    wire wrMapped = (s_axi_awaddr == `GSC_REG_FILTER) || (s_axi_awaddr == `GSC_REG_STATUS) ||
        (s_axi_awaddr == `GSC_REG_MEAS) || (s_axi_awaddr == `GSC_REG_DISCARD);
    wire rdTake = s_axi_arvalid && !rvalid_ff;
    wire rdHitS = s_axi_araddr == `GSC_REG_STATUS;
    wire rdHitF = s_axi_araddr == `GSC_REG_FILTER;
    wire rdHitM = s_axi_araddr == `GSC_REG_MEAS;
    wire rdHitD = s_axi_araddr == `GSC_REG_DISCARD;
    wire [31:0] rdMux = rdHitS ? {27'h0, txBusy, rangeHigh, meas.busy, 2'(mode_ff)} :
        rdHitF ? {24'h0, filter_ff} :
        rdHitM ? {meas.raw, meas.filt} :
        rdHitD ? {16'h0, discard_ff} : 32'h0;
    assign s_axi_awready = wrTake;
    assign s_axi_wready = wrTake;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign mode = mode_ff;
    assign filterVal = filter_ff;
    assign nvStore = nvStore_ff;
    assign nvModeOut = nvModeOut_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pst_ff <= GSC_P_LETTER;
            param_ff <= '0;
            ndig_ff <= '0;
            hasP_ff <= 1'b0;
            bad_ff <= 1'b0;
            letter_ff <= '0;
        end else begin
            pst_ff <= nxt_pst;
            param_ff <= nxt_param;
            ndig_ff <= nxt_ndig;
            hasP_ff <= nxt_hasP;
            bad_ff <= nxt_bad;
            if (rxTake && pst_ff == GSC_P_LETTER) begin
                letter_ff <= rxData;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pend_ff <= 1'b0;
            mode_ff <= GSC_STREAM;
            bootDone_ff <= 1'b0;
            filter_ff <= `GSC_FILT_RST;
            nvStore_ff <= 1'b0;
            nvModeOut_ff <= '0;
            discard_ff <= '0;
        end else begin
            pend_ff <= lineGood || (pend_ff && !cmdGo);
            bootDone_ff <= 1'b1;
            nvStore_ff <= setMode && (param_ff != '0);
            if (!bootDone_ff) begin
                mode_ff <= gsc_mode_t'(nvRestore);
            end else if (setMode) begin
                mode_ff <= gsc_mode_t'(param_ff[1:0]);
            end
            if (setMode && param_ff != '0) begin
                nvModeOut_ff <= param_ff[1:0];
            end
            if (cmdSend && okFset) begin
                filter_ff <= param_ff[7:0];
            end else if (wrFilter) begin
                filter_ff <= s_axi_wdata[7:0];
            end
            if (lineBad || (cmdGo && !cmdOk)) begin
                discard_ff <= discard_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            line_ff <= '0;
            txLeft_ff <= '0;
            due_ff <= 1'b0;
            tick_ff <= '0;
        end else begin
            if (txStart) begin
                line_ff <= newLine;
                txLeft_ff <= `GSC_LINE_BYTES;
            end else if (txShift) begin
                line_ff <= {line_ff[71:0], 8'h00};
                txLeft_ff <= txLeft_ff - 4'h1;
            end
            tick_ff <= (tick || mode_ff != GSC_STREAM) ? '0 : tick_ff + 26'h1;
            due_ff <= (mode_ff == GSC_STREAM) && (tick || (due_ff && !dueGo));
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `GSC_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff <= `GSC_RESP_OKAY;
            rdata_ff <= '0;
        end else begin
            if (wrTake) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wrMapped ? `GSC_RESP_OKAY : `GSC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (rdTake) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rdMux;
                rresp_ff <= (rdHitS || rdHitF || rdHitM || rdHitD) ?
                    `GSC_RESP_OKAY : `GSC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_line_lead_space: assert property (txStart |=> txData == `GSC_CH_SP)
        else $error("line does not start with a space");
    a_line_crlf_end: assert property (txValid && txReady && txLeft_ff == 4'h2 |->
        txData == `GSC_CH_CR ##1 txData == `GSC_CH_LF)
        else $error("line does not end with cr lf");
    a_tx_data_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("tx byte changed before taken");
    a_sleep_no_meas: assert property (cmdSend && sleeping |-> !(isFilt || isRaw))
        else $error("measurement reply sent in sleep");
    a_boot_mode: assert property (!bootDone_ff |=> mode_ff != GSC_SLEEP &&
        mode_ff == ((nvMode == `GSC_NV_POLL) ? GSC_POLL : GSC_STREAM))
        else $error("power-up mode wrong");
    a_filter_default: assert property (!bootDone_ff |-> filter_ff == `GSC_FILT_RST)
        else $error("filter default wrong");
    a_stream_defer: assert property (cmdGo && mode_ff == GSC_STREAM |-> !meas.busy)
        else $error("command handled during measurement");
    a_poll_quiet: assert property (dueGo |-> mode_ff == GSC_STREAM)
        else $error("unsolicited report outside streaming");
    a_scale_value: assert property (cmdSend && isScale |-> cmdVal ==
        (rangeHigh ? `GSC_SCALE_HI : `GSC_SCALE_LO))
        else $error("scaling multiplier wrong");
    a_mode_echo: assert property (setMode |=> mode_ff == gsc_mode_t'($past(param_ff[1:0]))
        && line_ff[71:64] == `GSC_CMD_MODE)
        else $error("mode not adopted or echoed");
    a_bad_kept: assert property (cmdGo && !cmdOk |=> $stable(filter_ff) && $stable(mode_ff)
        && !txBusy)
        else $error("discarded line changed state");
    a_filt_reply: assert property (cmdSend && isFilt |=> line_ff[55:0] ==
        {gsc_dec5($past(meas.filt)), `GSC_CH_CR, `GSC_CH_LF})
        else $error("filtered reply wrong");

    c_stream_report: cover property (dueGo ##1 txValid);
    c_mode_switch: cover property (setMode ##1 mode_ff == GSC_POLL);
    c_filter_set: cover property (cmdSend && okFset);
    c_discard: cover property (lineBad);
endmodule : gsc_cmd_port
`default_nettype wire

// *** src/gsc_pkg.sv ***
package gsc_pkg;
    typedef enum logic [1:0] {GSC_SLEEP, GSC_STREAM, GSC_POLL} gsc_mode_t;
    typedef enum logic [1:0] {GSC_P_LETTER, GSC_P_AFTER, GSC_P_DIGITS, GSC_P_LF} gsc_pst_t;
    typedef struct packed {
        logic [15:0] filt;
        logic [15:0] raw;
        logic busy;
    } gsc_meas_t;
endpackage : gsc_pkg

// *** verif/gsc_cmd_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module gsc_cmd_port_tb;
    import gsc_pkg::*;
    localparam int REP = 200;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic rxValid, rxReady, txValid, txReady, nvStore, slowSink, rangeHigh;
    logic [7:0] rxData, txData, filterVal;
    logic [1:0] nvMode, nvModeOut, s_axi_bresp, s_axi_rresp, r, lastNv;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    gsc_meas_t meas;
    gsc_mode_t mode;
    int nFail = 0;
    int cmpCount = 0;
    int nStore = 0;
    int waited;
    bit skipRep = 1'b0;
    always #5 core_clk = ~core_clk;

    gsc_cmd_port #(.REPORT_CYCLES(REP)) gsc_cmd_port_inst (
        .core_clk(core_clk), .rst(rst), .rxValid(rxValid), .rxData(rxData),
        .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
        .meas(meas), .rangeHigh(rangeHigh), .nvMode(nvMode), .nvStore(nvStore),
        .nvModeOut(nvModeOut), .mode(mode), .filterVal(filterVal),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    gsc_host_model host_inst (
        .core_clk(core_clk), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
        .txValid(txValid), .txData(txData), .txReady(txReady), .slowSink(slowSink));

    always @(posedge core_clk) begin
        if (nvStore === 1'b1) begin
            nStore <= nStore + 1;
            lastNv <= nvModeOut;
        end
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmpCount++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    function automatic string fmt(input string l, input int v);
        return $sformatf(" %s %05d\r\n", l, v);
    endfunction : fmt

    // waits for one reply line; unsolicited reports are passed over when skipRep is set
    task automatic expect_line(input string exp);
        string got;
        got = "";
        waited = 0;
        while (waited < 2000 && got == "") begin
            @(posedge core_clk);
            waited++;
            if (host_inst.lines.size() > 0) got = host_inst.lines.pop_front();
            if (skipRep && got == fmt("Z", 1521) && exp != got) got = "";
        end
        cmpCount++;
        if (got != exp) begin
            nFail++;
            $display("[ERR] line expected '%s' seen '%s'", exp.substr(1, 7), got.substr(1, 7));
        end
    endtask : expect_line

    task automatic expect_none(input int n);
        repeat (n) @(posedge core_clk);
        chk("lines sent", 32'h0, host_inst.lines.size());
    endtask : expect_none

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge core_clk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rs = s_axi_rresp;
    endtask : axi_rd

    initial begin
        repeat (20000) @(posedge core_clk);
        nFail++;
        $display("[ERR] watchdog expected finish seen hang");
        conclude();
    end

    initial begin
        nvMode = 2'h2;
        rangeHigh = 1'b0;
        slowSink = 1'b0;
        meas = '{filt: 16'h05f1, raw: 16'h0029, busy: 1'b0};
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("power-up mode", GSC_POLL, mode);
        chk("filter default", 32'h10, filterVal);
        host_inst.send_line("a\r\n");
        expect_line(fmt("a", 16));
        slowSink <= 1'b1;
        host_inst.send_line("A 255\r\n");
        expect_line(fmt("A", 255));
        slowSink <= 1'b0;
        chk("filter set", 32'hff, filterVal);
        host_inst.send_line("A 256\r\n");
        host_inst.send_line("Q\r\n");
        expect_none(60);
        chk("filter kept", 32'hff, filterVal);
        host_inst.send_line(".\r\n");
        expect_line(fmt(".", 10));
        rangeHigh <= 1'b1;
        host_inst.send_line(".\r\n");
        expect_line(fmt(".", 100));
        host_inst.send_line("Z\r\n");
        expect_line(fmt("Z", 1521));
        host_inst.send_line("z\r\n");
        expect_line(fmt("z", 41));
        host_inst.send_line("K 0\r\n");
        expect_line(fmt("K", 0));
        chk("sleep mode", GSC_SLEEP, mode);
        chk("sleep not stored", 32'h0, nStore);
        host_inst.send_line("Z\r\n");
        expect_none(60);
        axi_rd(12'h00c, d, r);
        chk("discard count", 32'h3, d[15:0]);
        host_inst.send_line("a\r\n");
        expect_line(fmt("a", 255));
        chk("sleep answer delay", 32'h1, waited < 20);
        host_inst.send_line("K 1\r\n");
        expect_line(fmt("K", 1));
        chk("stream mode", GSC_STREAM, mode);
        chk("store stream", 32'h1, lastNv);
        meas.busy <= 1'b1;
        host_inst.send_line("a\r\n");
        expect_none(100);
        meas.busy <= 1'b0;
        expect_line(fmt("a", 255));
        expect_line(fmt("Z", 1521));
        expect_line(fmt("Z", 1521));
        chk("report spacing", 32'h1, waited >= REP - 3 && waited <= REP + 3);
        skipRep = 1'b1;
        host_inst.send_line("K 2\r\n");
        expect_line(fmt("K", 2));
        skipRep = 1'b0;
        chk("poll mode", GSC_POLL, mode);
        chk("store poll", 32'h2, lastNv);
        chk("store count", 32'h2, nStore);
        expect_none(REP + 50);
        host_inst.send_line("Z\r\n");
        expect_line(fmt("Z", 1521));
        axi_wr(12'h004, 32'h2a, r);
        chk("filter write resp", 32'h0, r);
        host_inst.send_line("a\r\n");
        expect_line(fmt("a", 42));
        axi_rd(12'h000, d, r);
        chk("status mode", 32'h2, d[1:0]);
        chk("status range", 32'h1, d[3]);
        axi_rd(12'h010, d, r);
        chk("unmapped read resp", 32'h2, r);
        axi_wr(12'h010, 32'h1, r);
        chk("unmapped write resp", 32'h2, r);
        conclude();
    end
endmodule : gsc_cmd_port_tb
`default_nettype wire

// *** verif/gsc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module gsc_host_model (
    // clock
    input wire logic core_clk,
    // bytes to the port
    output logic rxValid,
    output logic [7:0] rxData,
    input wire logic rxReady,
    // bytes from the port
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady,
    // sink pacing
    input wire logic slowSink
);
    string lines[$];
    string cur = "";
    initial begin
        rxValid = 1'b0;
        rxData = 8'h00;
        txReady = 1'b1;
    end
    // each byte held until taken; a released line shows the inverse value
    task automatic send_line(input string s);
        for (int i = 0; i < s.len(); i++) begin
            rxValid <= 1'b1;
            rxData <= s[i];
            do @(posedge core_clk); while (rxReady !== 1'b1);
        end
        rxValid <= 1'b0;
        rxData <= ~s[s.len() - 1];
        @(posedge core_clk);
    endtask : send_line
    always @(posedge core_clk) begin
        if (txValid === 1'b1 && txReady === 1'b1) begin
            cur = {cur, string'(txData)};
            if (txData === 8'h0a) begin
                lines.push_back(cur);
                cur = "";
            end
        end
        txReady <= slowSink ? ~txReady : 1'b1;
    end
endmodule : gsc_host_model
`default_nettype wire
